// ==== src/dom_pkg.sv ====
package dom_pkg;
   // active command source of the drive
   typedef enum logic [1:0] {
      DOM_PANEL,
      DOM_EXT,
      DOM_COMMS,
      DOM_COMB
   } dom_mode_t;

   // operation mode selection values
   localparam logic [3:0] OPM_SWITCH = 4'h0;
   localparam logic [3:0] OPM_PANEL_FIXED = 4'h1;
   localparam logic [3:0] OPM_EXT_FIXED = 4'h2;
   localparam logic [3:0] OPM_COMB_A = 4'h3;
   localparam logic [3:0] OPM_COMB_B = 4'h4;
   localparam logic [3:0] OPM_RUN_SWITCH = 4'h6;
   localparam logic [3:0] OPM_INTERLOCK = 4'h7;
   localparam logic [3:0] OPM_RESET = 4'h0;

   // communication startup selection values
   localparam logic [3:0] ST_AS_OPM = 4'h0;
   localparam logic [3:0] ST_COMMS = 4'h1;
   localparam logic [3:0] ST_COMMS_KEEP = 4'h2;
   localparam logic [3:0] ST_PANEL_COMMS = 4'ha;
   localparam logic [3:0] ST_PANEL_COMMS_KEEP = 4'hc;
   localparam logic [3:0] ST_RESET = 4'h0;

   // parameter write protection value that allows parameter writes
   localparam logic [1:0] WP_ALLOW_ALL = 2'h0;

   // comms-mode command source value meaning option control
   localparam logic CMD_SRC_OPTION = 1'h0;

   // positions of the pin inputs in the synchroniser vector
   localparam int PIN_PANEL_EXT = 0;
   localparam int PIN_PANEL_COMMS = 1;
   localparam int PIN_COMMS_EXT = 2;
   localparam int PIN_INTERLOCK = 3;
   localparam int PIN_OUT_STOP = 4;
   localparam int PIN_START = 5;
   localparam int PIN_COUNT = 6;

   localparam dom_mode_t MODE_RESET = DOM_EXT;
endpackage : dom_pkg

// ==== src/dom_mode_sel.sv ====
module dom_mode_sel
   import dom_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic panel_external_switch_input,
   input wire logic panel_comms_switch_input,
   input wire logic comms_external_switch_input,
   input wire logic panel_interlock_input,
   input wire logic output_stop_input,
   input wire logic start_command_input,
   input wire logic panel_external_assigned,
   input wire logic panel_comms_assigned,
   input wire logic comms_external_assigned,
   input wire logic interlock_assigned,
   input wire logic motor_stopped,
   input wire logic comms_mode_command_source,
   input wire logic comm_option_fitted,
   input wire logic [1:0] parameter_write_protection,
   input wire logic panel_toggle_key,
   input wire logic power_restored,
   input wire logic opm_write,
   input wire logic [3:0] opm_write_data,
   input wire logic startup_write,
   input wire logic [3:0] startup_write_data,
   output dom_pkg::dom_mode_t drive_mode,
   output logic change_pending,
   output logic output_stop,
   output logic param_write_enable,
   output logic [3:0] operation_mode_selection,
   output logic [3:0] comms_startup_selection
);
   import dom_pkg::*;

   // two-stage synchronisers for the terminal pins
   logic [PIN_COUNT-1:0] pin_raw;
   logic [PIN_COUNT-1:0] pin_meta_reg;
   logic [PIN_COUNT-1:0] pin_sync_reg;
   assign pin_raw = {start_command_input, output_stop_input, panel_interlock_input,
                     comms_external_switch_input, panel_comms_switch_input, panel_external_switch_input};

   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               pin_meta_reg[gi] <= 1'h0;
               pin_sync_reg[gi] <= 1'h0;
            end else begin
               pin_meta_reg[gi] <= pin_raw[gi];
               pin_sync_reg[gi] <= pin_meta_reg[gi];
            end
         end
      end
   endgenerate

   logic x16;
   logic x65;
   logic x66;
   logic interlock_on;
   logic start_on;
   logic stopped;
   assign x16 = pin_sync_reg[PIN_PANEL_EXT];
   assign x65 = pin_sync_reg[PIN_PANEL_COMMS];
   assign x66 = pin_sync_reg[PIN_COMMS_EXT];
   assign start_on = pin_sync_reg[PIN_START];
   // output-stop pin stands in when no interlock terminal exists
   assign interlock_on = interlock_assigned ? pin_sync_reg[PIN_INTERLOCK] : pin_sync_reg[PIN_OUT_STOP];
   // a stop means motor at rest or no start command
   assign stopped = motor_stopped || !start_on;

   function automatic logic is_panel_comms_st(input logic [3:0] st);
      return (st == ST_PANEL_COMMS) || (st == ST_PANEL_COMMS_KEEP);
   endfunction : is_panel_comms_st

   function automatic logic is_comb(input logic [3:0] opm);
      return (opm == OPM_COMB_A) || (opm == OPM_COMB_B);
   endfunction : is_comb

   // comms falls back to panel when the option is missing
   function automatic dom_mode_t no_comms(input dom_mode_t m, input logic blk);
      return (m == DOM_COMMS && blk) ? DOM_PANEL : m;
   endfunction : no_comms

   // settings and state registers
   logic [3:0] opm_reg;
   logic [3:0] opm_next;
   logic [3:0] st_reg;
   logic [3:0] st_next;
   dom_mode_t mode_reg;
   dom_mode_t mode_next;
   logic init_reg;
   logic init_next;
   logic pending_reg;
   logic pending_next;
   logic stop_reg;
   logic stop_next;
   logic wen_reg;
   logic wen_next;

   logic blk;
   logic lockout;
   logic forced;
   logic allowed;
   dom_mode_t target;
   dom_mode_t start_mode;

   assign blk = (comms_mode_command_source == CMD_SRC_OPTION) && !comm_option_fitted;
   // interlock off under setting 7 locks out all writes but the selection
   assign lockout = (opm_reg == OPM_INTERLOCK) && !interlock_on;

   // mode at power on or reset
   always_comb begin
      start_mode = DOM_EXT;
      if (opm_reg == OPM_PANEL_FIXED) begin
         start_mode = DOM_PANEL;
      end else if (is_comb(opm_reg)) begin
         start_mode = DOM_COMB;
      end else if (st_reg == ST_AS_OPM) begin
         start_mode = DOM_EXT;
      end else if (opm_reg == OPM_INTERLOCK) begin
         start_mode = (interlock_on && !is_panel_comms_st(st_reg)) ? DOM_COMMS : DOM_EXT;
      end else begin
         start_mode = DOM_COMMS;
      end
      start_mode = no_comms(start_mode, blk);
   end

   // target mode, resolved selection first, then interlock, then inputs by rank
   always_comb begin
      target = mode_reg;
      if (opm_reg == OPM_PANEL_FIXED) begin
         target = DOM_PANEL;
      end else if (is_comb(opm_reg)) begin
         target = DOM_COMB;
      end else if (opm_reg == OPM_INTERLOCK && !interlock_on) begin
         target = DOM_EXT;
      end else if (opm_reg == OPM_EXT_FIXED) begin
         if (is_panel_comms_st(st_reg)) begin
            target = DOM_COMMS;
         end else if (comms_external_assigned) begin
            target = x66 ? DOM_COMMS : DOM_EXT;
         end else begin
            target = (mode_reg == DOM_PANEL) ? DOM_EXT : mode_reg;
         end
      end else if (comms_external_assigned && !is_panel_comms_st(st_reg)) begin
         if (x66) begin
            target = DOM_COMMS;
         end else if (panel_comms_assigned) begin
            target = x65 ? DOM_PANEL : DOM_EXT;
         end else if (panel_external_assigned) begin
            target = x16 ? DOM_EXT : DOM_PANEL;
         end else begin
            target = DOM_EXT;
         end
      end else if (panel_comms_assigned && is_panel_comms_st(st_reg)) begin
         if (x65) begin
            target = (comms_external_assigned && x66) ? DOM_COMMS : DOM_PANEL;
         end else if (panel_external_assigned) begin
            target = x16 ? DOM_EXT : DOM_PANEL;
         end else begin
            target = DOM_COMMS;
         end
      end else if (panel_external_assigned) begin
         target = x16 ? DOM_EXT : DOM_PANEL;
      end else if (is_panel_comms_st(st_reg) && panel_toggle_key) begin
         // the panel key alone swaps between panel and comms
         target = (mode_reg == DOM_COMMS) ? DOM_PANEL : DOM_COMMS;
      end
      target = no_comms(target, blk);
   end

   // fixed settings and forced external apply at once, even while running
   assign forced = (opm_reg == OPM_PANEL_FIXED) || is_comb(opm_reg) || (opm_reg == OPM_INTERLOCK && !interlock_on)
                   || (opm_reg == OPM_EXT_FIXED && (mode_reg == DOM_PANEL || is_panel_comms_st(st_reg)));
   assign allowed = forced || stopped || (opm_reg == OPM_RUN_SWITCH);

   // next state of settings, mode and status flags
   always_comb begin
      opm_next = opm_reg;
      st_next = st_reg;
      mode_next = mode_reg;
      init_next = 1'h0;
      pending_next = 1'h0;
      // selection writes only at a stop; protection does not block them
      if (opm_write && stopped) begin
         opm_next = opm_write_data;
      end
      if (startup_write && stopped && !lockout) begin
         st_next = startup_write_data;
      end
      if (init_reg) begin
         mode_next = start_mode;
      end else if (power_restored && st_reg != ST_COMMS_KEEP && st_reg != ST_PANEL_COMMS_KEEP) begin
         // only the keep settings restore the mode held before the outage
         init_next = 1'h1;
      end else if (allowed) begin
         mode_next = target;
      end else begin
         pending_next = (target != mode_reg);
      end
      // output stop in external mode while interlocked, else the stop pin if an interlock terminal is assigned
      if (opm_reg == OPM_INTERLOCK) begin
         stop_next = interlock_on && (mode_next == DOM_EXT);
      end else begin
         stop_next = interlock_assigned && pin_sync_reg[PIN_OUT_STOP];
      end
      wen_next = !lockout && (parameter_write_protection == WP_ALLOW_ALL) && stopped;
   end

   // registers only
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         opm_reg <= OPM_RESET;
         st_reg <= ST_RESET;
         mode_reg <= MODE_RESET;
         init_reg <= 1'h1;
         pending_reg <= 1'h0;
         stop_reg <= 1'h0;
         wen_reg <= 1'h0;
      end else begin
         opm_reg <= opm_next;
         st_reg <= st_next;
         mode_reg <= mode_next;
         init_reg <= init_next;
         pending_reg <= pending_next;
         stop_reg <= stop_next;
         wen_reg <= wen_next;
      end
   end

   assign drive_mode = mode_reg;
   assign change_pending = pending_reg;
   assign output_stop = stop_reg;
   assign param_write_enable = wen_reg;
   assign operation_mode_selection = opm_reg;
   assign comms_startup_selection = st_reg;

   // checks, the quiet cycle around init and restore excluded
   logic calm;
   assign calm = !init_reg && !power_restored;

   property p_fixed_panel;
      @(posedge sys_clk) disable iff (!rst_n) (calm && opm_reg == OPM_PANEL_FIXED) |=> (mode_reg == DOM_PANEL);
   endproperty
   a_fixed_panel: assert property (p_fixed_panel) else $error("setting 1 did not give panel mode");

   property p_comms_fixed;
      @(posedge sys_clk) disable iff (!rst_n)
         (calm && opm_reg == OPM_EXT_FIXED && is_panel_comms_st(st_reg) && !blk) |=> (mode_reg == DOM_COMMS);
   endproperty
   a_comms_fixed: assert property (p_comms_fixed) else $error("setting 2 with startup 10/12 not comms");

   property p_interlock_force;
      @(posedge sys_clk) disable iff (!rst_n)
         (calm && opm_reg == OPM_INTERLOCK && !interlock_on) |=> (mode_reg == DOM_EXT && !output_stop);
   endproperty
   a_interlock_force: assert property (p_interlock_force) else $error("interlock off did not force external");

   property p_no_panel;
      @(posedge sys_clk) disable iff (!rst_n) (calm && opm_reg == OPM_EXT_FIXED && !blk) |=> (mode_reg != DOM_PANEL);
   endproperty
   a_no_panel: assert property (p_no_panel) else $error("panel mode entered under setting 2");

   property p_run_switch;
      @(posedge sys_clk) disable iff (!rst_n)
         (calm && opm_reg == OPM_RUN_SWITCH && !stopped) |=> (mode_reg == $past(target));
   endproperty
   a_run_switch: assert property (p_run_switch) else $error("setting 6 did not switch while running");

   property p_pending;
      @(posedge sys_clk) disable iff (!rst_n)
         (calm && !allowed && target != mode_reg) |=> ($stable(mode_reg) && change_pending);
   endproperty
   a_pending: assert property (p_pending) else $error("running change not held pending");

   property p_comms_ext;
      @(posedge sys_clk) disable iff (!rst_n)
         (calm && opm_reg == OPM_SWITCH && st_reg == ST_AS_OPM && comms_external_assigned && x66 && stopped && !blk)
         |=> (mode_reg == DOM_COMMS);
   endproperty
   a_comms_ext: assert property (p_comms_ext) else $error("comms-external input did not give comms");

   property p_panel_comms;
      @(posedge sys_clk) disable iff (!rst_n)
         (calm && opm_reg == OPM_SWITCH && is_panel_comms_st(st_reg) && panel_comms_assigned && x65 && stopped)
         |=> (mode_reg == ((($past(comms_external_assigned) && $past(x66)) && !$past(blk)) ? DOM_COMMS : DOM_PANEL));
   endproperty
   a_panel_comms: assert property (p_panel_comms) else $error("panel-comms input gave wrong mode");

   property p_no_option;
      @(posedge sys_clk) disable iff (!rst_n) (calm && blk && allowed) |=> (mode_reg != DOM_COMMS);
   endproperty
   a_no_option: assert property (p_no_option) else $error("comms chosen without option");

   property p_startup;
      @(posedge sys_clk) disable iff (!rst_n)
         (init_reg && opm_reg == OPM_SWITCH && st_reg != ST_AS_OPM && !blk) |=> (mode_reg == DOM_COMMS);
   endproperty
   a_startup: assert property (p_startup) else $error("startup did not enter comms mode");

   property p_opm_write;
      @(posedge sys_clk) disable iff (!rst_n) (opm_write && stopped) |=> (opm_reg == $past(opm_write_data));
   endproperty
   a_opm_write: assert property (p_opm_write) else $error("selection write lost at a stop");

   property p_lockout;
      // write enable registers the lockout of the write cycle itself, so both are judged one edge later
      @(posedge sys_clk) disable iff (!rst_n) (startup_write && lockout) |=> ($stable(st_reg) && !param_write_enable);
   endproperty
   a_lockout: assert property (p_lockout) else $error("startup write accepted under interlock");

   c_pending: cover property (@(posedge sys_clk) disable iff (!rst_n) change_pending ##1 !change_pending);
   c_toggle: cover property (@(posedge sys_clk) disable iff (!rst_n) panel_toggle_key && allowed && calm);
   c_forced: cover property (@(posedge sys_clk) disable iff (!rst_n) opm_reg == OPM_INTERLOCK && !interlock_on);
   c_restore: cover property (@(posedge sys_clk) disable iff (!rst_n) power_restored && st_reg == ST_COMMS_KEEP);
endmodule : dom_mode_sel

// ==== tb/dom_term_model.sv ====
// input terminals and operation panel switches seen by the selector
module dom_term_model (
   input wire logic sys_clk,
   output logic panel_external_switch_input,
   output logic panel_comms_switch_input,
   output logic comms_external_switch_input,
   output logic panel_interlock_input,
   output logic output_stop_input,
   output logic start_command_input,
   output logic panel_external_assigned,
   output logic panel_comms_assigned,
   output logic comms_external_assigned,
   output logic interlock_assigned
);
   timeunit 1ns;
   timeprecision 1ps;

   // terminals come up released, nothing assigned, stop input on
   initial begin
      {panel_external_switch_input, panel_comms_switch_input, comms_external_switch_input} = 3'h0;
      panel_interlock_input = 1'b1;
      output_stop_input = 1'b1;
      start_command_input = 1'b0;
      {panel_external_assigned, panel_comms_assigned, comms_external_assigned, interlock_assigned} = 4'h0;
   end

   // function codes are set on the terminals before their pins are relied upon
   task automatic assign_fn(input logic a16, input logic a65, input logic a66, input logic ail);
      @(negedge sys_clk);
      panel_external_assigned = a16;
      panel_comms_assigned = a65;
      comms_external_assigned = a66;
      interlock_assigned = ail;
   endtask : assign_fn

   // levels change away from the sampling edge, like a debounced contact
   task automatic set_pins(input logic p16, input logic p65, input logic p66, input logic pil, input logic pms,
                           input logic pst);
      @(negedge sys_clk);
      panel_external_switch_input = p16;
      panel_comms_switch_input = p65;
      comms_external_switch_input = p66;
      panel_interlock_input = pil;
      output_stop_input = pms;
      start_command_input = pst;
   endtask : set_pins
endmodule : dom_term_model

// ==== tb/dom_mode_sel_tb_top.sv ====
module dom_mode_sel_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import dom_pkg::*;

   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic motor_stopped = 1'b1;
   logic comms_mode_command_source = 1'b1;
   logic comm_option_fitted = 1'b1;
   logic [1:0] parameter_write_protection = 2'h0;
   logic panel_toggle_key = 1'b0;
   logic power_restored = 1'b0;
   logic opm_write = 1'b0;
   logic [3:0] opm_write_data = 4'h0;
   logic startup_write = 1'b0;
   logic [3:0] startup_write_data = 4'h0;
   logic x16, x65, x66, pil, pms, pst, a16, a65, a66, ail;
   dom_mode_t drive_mode;
   logic change_pending, output_stop, param_write_enable;
   logic [3:0] operation_mode_selection, comms_startup_selection;
   int error_cnt = 0;
   int compares = 0;

   // 100 MHz system clock
   always #5 sys_clk = ~sys_clk;

   dom_term_model u_term (.sys_clk(sys_clk), .panel_external_switch_input(x16), .panel_comms_switch_input(x65),
      .comms_external_switch_input(x66), .panel_interlock_input(pil), .output_stop_input(pms),
      .start_command_input(pst), .panel_external_assigned(a16), .panel_comms_assigned(a65),
      .comms_external_assigned(a66), .interlock_assigned(ail));

   dom_mode_sel uut (.sys_clk(sys_clk), .rst_n(rst_n), .panel_external_switch_input(x16),
      .panel_comms_switch_input(x65), .comms_external_switch_input(x66), .panel_interlock_input(pil),
      .output_stop_input(pms), .start_command_input(pst), .panel_external_assigned(a16),
      .panel_comms_assigned(a65), .comms_external_assigned(a66), .interlock_assigned(ail),
      .motor_stopped(motor_stopped), .comms_mode_command_source(comms_mode_command_source),
      .comm_option_fitted(comm_option_fitted), .parameter_write_protection(parameter_write_protection),
      .panel_toggle_key(panel_toggle_key), .power_restored(power_restored), .opm_write(opm_write),
      .opm_write_data(opm_write_data), .startup_write(startup_write), .startup_write_data(startup_write_data),
      .drive_mode(drive_mode), .change_pending(change_pending), .output_stop(output_stop),
      .param_write_enable(param_write_enable), .operation_mode_selection(operation_mode_selection),
      .comms_startup_selection(comms_startup_selection));

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic mode_is(input dom_mode_t exp);
      chk("drive_mode", {2'h0, drive_mode}, {2'h0, exp});
   endtask : mode_is

   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : cyc

   // pins need two sync edges plus the mode register, so five cycles is ample
   task automatic pins(input logic p16, input logic p65, input logic p66, input logic pil_v, input logic pms_v,
                       input logic pst_v);
      u_term.set_pins(p16, p65, p66, pil_v, pms_v, pst_v);
      cyc(5);
   endtask : pins

   // both selections written in one pulse, then settle
   task automatic wr(input logic [3:0] opm, input logic [3:0] st);
      @(negedge sys_clk);
      opm_write = 1'b1;
      opm_write_data = opm;
      startup_write = 1'b1;
      startup_write_data = st;
      @(negedge sys_clk);
      opm_write = 1'b0;
      startup_write = 1'b0;
      cyc(4);
   endtask : wr

   task automatic pulse(input int which);
      @(negedge sys_clk);
      if (which == 0) panel_toggle_key = 1'b1;
      else power_restored = 1'b1;
      @(negedge sys_clk);
      panel_toggle_key = 1'b0;
      power_restored = 1'b0;
      cyc(4);
   endtask : pulse

   task automatic t_reset;
      cyc(2);
      mode_is(DOM_EXT);
      chk("opm_sel", operation_mode_selection, 4'h0);
      chk("st_sel", comms_startup_selection, 4'h0);
      chk("pending", {3'h0, change_pending}, 4'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_comms_ext;
      u_term.assign_fn(1'b0, 1'b0, 1'b1, 1'b0);
      pins(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
      mode_is(DOM_COMMS);
      comm_option_fitted = 1'b0;
      comms_mode_command_source = 1'b0;
      cyc(4);
      mode_is(DOM_PANEL);
      comm_option_fitted = 1'b1;
      cyc(4);
      mode_is(DOM_COMMS);
      pins(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      mode_is(DOM_EXT);
      u_term.assign_fn(1'b1, 1'b0, 1'b1, 1'b0);
      cyc(4);
      mode_is(DOM_PANEL);
      pins(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      mode_is(DOM_EXT);
      $display("test comms external done");
   endtask : t_comms_ext

   task automatic t_panel_comms;
      u_term.assign_fn(1'b0, 1'b1, 1'b0, 1'b0);
      pins(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      wr(4'h0, 4'ha);
      mode_is(DOM_PANEL);
      pins(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      mode_is(DOM_COMMS);
      u_term.assign_fn(1'b0, 1'b1, 1'b1, 1'b0);
      pins(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
      mode_is(DOM_COMMS);
      u_term.assign_fn(1'b1, 1'b1, 1'b0, 1'b0);
      pins(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      mode_is(DOM_PANEL);
      pins(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      mode_is(DOM_EXT);
      $display("test panel comms done");
   endtask : t_panel_comms

   task automatic t_fixed;
      logic [3:0] sel [4] = '{4'h1, 4'h2, 4'h3, 4'h4};
      dom_mode_t exp [4] = '{DOM_PANEL, DOM_COMMS, DOM_COMB, DOM_COMB};
      pins(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      for (int i = 0; i < 4; i++) begin
         wr(sel[i], 4'ha);
         mode_is(exp[i]);
      end
      wr(4'h2, 4'h0);
      u_term.assign_fn(1'b1, 1'b1, 1'b1, 1'b0);
      pins(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
      mode_is(DOM_COMMS);
      pins(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      mode_is(DOM_EXT);
      $display("test fixed modes done");
   endtask : t_fixed

   task automatic t_interlock;
      wr(4'h7, 4'h0);
      u_term.assign_fn(1'b0, 1'b0, 1'b1, 1'b1);
      pins(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
      mode_is(DOM_EXT);
      chk("pwe", {3'h0, param_write_enable}, 4'h0);
      // startup write under lockout is refused, the selection write still lands
      wr(4'h7, 4'h1);
      chk("st_sel", comms_startup_selection, 4'h0);
      chk("opm_sel", operation_mode_selection, 4'h7);
      pins(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
      mode_is(DOM_COMMS);
      chk("pwe", {3'h0, param_write_enable}, 4'h1);
      pins(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      chk("out_stop", {3'h0, output_stop}, 4'h1);
      u_term.assign_fn(1'b0, 1'b0, 1'b1, 1'b0);
      pins(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      mode_is(DOM_EXT);
      pins(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      $display("test interlock done");
   endtask : t_interlock

   task automatic t_running;
      wr(4'h0, 4'h0);
      mode_is(DOM_EXT);
      motor_stopped = 1'b0;
      pins(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
      mode_is(DOM_EXT);
      chk("pending", {3'h0, change_pending}, 4'h1);
      wr(4'h1, 4'h0);
      chk("opm_sel", operation_mode_selection, 4'h0);
      motor_stopped = 1'b1;
      cyc(4);
      mode_is(DOM_COMMS);
      chk("pending", {3'h0, change_pending}, 4'h0);
      wr(4'h6, 4'h0);
      motor_stopped = 1'b0;
      pins(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      mode_is(DOM_EXT);
      chk("pending", {3'h0, change_pending}, 4'h0);
      motor_stopped = 1'b1;
      pins(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      $display("test running done");
   endtask : t_running

   task automatic t_startup;
      u_term.assign_fn(1'b0, 1'b0, 1'b0, 1'b0);
      parameter_write_protection = 2'h1;
      wr(4'h4, 4'h0);
      chk("opm_sel", operation_mode_selection, 4'h4);
      parameter_write_protection = 2'h0;
      wr(4'h0, 4'h1);
      pulse(1);
      mode_is(DOM_COMMS);
      wr(4'h0, 4'ha);
      pulse(0);
      mode_is(DOM_PANEL);
      wr(4'h0, 4'hc);
      chk("st_sel", comms_startup_selection, 4'hc);
      pulse(1);
      mode_is(DOM_PANEL);
      wr(4'h0, 4'ha);
      pulse(1);
      mode_is(DOM_COMMS);
      $display("test startup done");
   endtask : t_startup

   // watchdog: the sequence needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      $display("[ERR] watchdog expected finish seen hang");
      test_done();
   end

   // main sequence: reset held 20 cycles, released on a falling edge
   initial begin
      repeat (20) @(negedge sys_clk);
      rst_n = 1'b1;
      t_reset();
      t_comms_ext();
      t_panel_comms();
      t_fixed();
      t_interlock();
      t_running();
      t_startup();
      test_done();
   end
endmodule : dom_mode_sel_tb_top
